// [shared/lmbp_regs.vh]
// Constants for the local-memory bus pin sequencer: phase boundaries,
// address decode limits and clock step sizes.
// Assumes a memory cycle split into sixteen sixteenths, counted 0..15.
`ifndef LMBP_REGS_VH
`define LMBP_REGS_VH

// Sixteenth counter width and phase boundaries
`define LMBP_PHASE_W        4
`define LMBP_Q2_FIRST       4'h4
`define LMBP_DATA_FIRST     4'h8
`define LMBP_CAS_FIRST      4'h5
`define LMBP_CAS_LAST       4'h7
`define LMBP_REF_CAS_LAST   4'h2
`define LMBP_CLKB_LAG       4'h2

// Phase steps per core clock: slower bus divides by 8, faster by 4
`define LMBP_STEP_SLOW      4'h1
`define LMBP_STEP_FAST      4'h2

// Address decode, 21-bit byte address: chapter in [20:16]
`define LMBP_ADDR_W         21
`define LMBP_ROM_LAST       21'h00000F
`define LMBP_EPROM_LO       21'h000010
`define LMBP_EPROM_HI       21'h00FFFF
`define LMBP_EPROM_CHAP     5'h1F

// Phase reset value; direction drive level loaded every clock out of reset
`define LMBP_PHASE_RST      4'h0
`define LMBP_DIR_OE_RST     1'b1

`endif

// [rtl/lmbp_sync.v]
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes every bit is independent; no bus coherence across bits is kept.
`timescale 1ns/100ps

module lmbp_sync #(
    parameter W = 8                  // Number of bits carried
) (
    input  wire         core_clk,    // Core clock
    input  wire [W-1:0] pin_in,      // Raw pin levels
    output wire [W-1:0] pin_sync     // Levels after two flops
);

    ////////////////////////////////////////////////////////////////////////
    // Stages; data only, so no reset: strap capture needs the live value
    reg [W-1:0] meta_q;              // First stage, read only by second
    reg [W-1:0] sync_q;              // Second stage, safe to use

    // Two flops in series
    always @(posedge core_clk) begin
        meta_q <= pin_in;
        sync_q <= meta_q;
    end

    assign pin_sync = sync_q;

endmodule

// [rtl/lmbp_pins.v]
// Local-memory bus pin sequencer: bus clocks, extended address and parity
// multiplexing, strobes and buffer controls for DRAM, EPROM and ROM.
// Assumes core_clk stands in for the oscillator and that the request side
// runs on core_clk. Lanes are driven elsewhere; only sampled here.
`timescale 1ns/100ps
`include "lmbp_regs.vh"

module lmbp_pins #(
    parameter PARITY_ODD = 1'b1               // Odd parity when set
) (
    input  wire        core_clk,                   // Core clock, 40 MHz
    input  wire        rst_n,                      // Synchronous reset
    input  wire        clock_divider_select,       // Pin: divider select
    input  wire        bootstrap_input,            // Pin: boot strap
    input  wire        req_valid,                  // Access request
    input  wire        req_write,                  // Request is a write
    input  wire        req_refresh,                // Request is refresh
    input  wire [20:0] req_addr,                   // Byte address
    input  wire [15:0] req_wdata,                  // Write data
    input  wire        parity_check_en,            // Check read parity
    input  wire [7:0]  addr_data_lane_high_i,      // Pin: high lane in
    input  wire [7:0]  addr_data_lane_low_i,       // Pin: low lane in
    input  wire        ext_addr_parity_high_pin_i, // Pin: high parity in
    input  wire        ext_addr_parity_low_pin_i,  // Pin: low parity in
    output reg         req_taken,                  // Request accepted
    output reg         rd_valid,                   // Read data ready
    output reg  [15:0] rd_data,                    // Read data
    output reg         parity_error,               // Read parity bad
    output reg         boot_source,                // Boot bit state
    output reg         local_bus_clock_a,          // Bus clock one
    output reg         local_bus_clock_b,          // Bus clock two
    output reg         buffer_enable_n,            // Buffer enable
    output reg         data_direction_o,           // Direction level
    output reg         data_direction_oe,          // Direction drive
    output reg         burned_addr_rom_oe_n,       // Address ROM enable
    output reg         column_strobe_n,            // Column strobe
    output reg         refresh_in_progress,        // Refresh flag
    output reg         ext_addr_upper_pin_o,       // Upper pin level
    output reg         ext_addr_upper_pin_oe,      // Upper pin drive
    output reg         ext_addr_parity_high_pin_o, // High pin level
    output reg         ext_addr_parity_high_pin_oe,// High pin drive
    output reg         ext_addr_parity_low_pin_o,  // Low pin level
    output reg         ext_addr_parity_low_pin_oe  // Low pin drive
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire [19:0] pins_s;                // Synchronised pin bundle
    wire        div_sel_s;             // Divider select, synced
    wire        boot_pin_s;            // Bootstrap, synced
    wire [7:0]  lane_h_s;              // High lane, synced
    wire [7:0]  lane_l_s;              // Low lane, synced
    wire        par_h_s;               // High parity in, synced
    wire        par_l_s;               // Low parity in, synced

    lmbp_sync #(
        .W        (20)
    ) u_sync (
        .core_clk (core_clk),
        .pin_in   ({clock_divider_select, bootstrap_input,
                    addr_data_lane_high_i, addr_data_lane_low_i,
                    ext_addr_parity_high_pin_i, ext_addr_parity_low_pin_i}),
        .pin_sync (pins_s)
    );

    assign div_sel_s  = pins_s[19];
    assign boot_pin_s = pins_s[18];
    assign lane_h_s   = pins_s[17:10];
    assign lane_l_s   = pins_s[9:2];
    assign par_h_s    = pins_s[1];
    assign par_l_s    = pins_s[0];

    ////////////////////////////////////////////////////////////////////////
    // Cycle state
    reg  [3:0]  phase_q;               // Sixteenth within memory cycle
    reg         fast_q;                // Faster bus, step of two
    reg         active_q;              // An access occupies this cycle
    reg         cyc_write_q;           // Current cycle writes
    reg         cyc_refresh_q;         // Current cycle refreshes
    reg  [20:0] cyc_addr_q;            // Current cycle address
    reg  [15:0] cyc_wdata_q;           // Current cycle write data
    reg         boot_q;                // Boot source bit

    wire [3:0]  step;                  // Phase advance per clock
    wire [4:0]  phase_sum;             // Phase plus step, with carry
    wire        wrap;                  // Last clock of memory cycle

    // Divider chosen per cycle so the bus clocks never glitch mid-cycle
    assign step      = fast_q ? `LMBP_STEP_FAST : `LMBP_STEP_SLOW;
    assign phase_sum = {1'b0, phase_q} + {1'b0, step};
    assign wrap      = phase_sum[4];

    ////////////////////////////////////////////////////////////////////////
    // Phase counter and request capture
    always @(posedge core_clk) begin
        if (!rst_n) begin
            phase_q       <= `LMBP_PHASE_RST;
            fast_q        <= 1'b0;
            active_q      <= 1'b0;
            cyc_write_q   <= 1'b0;
            cyc_refresh_q <= 1'b0;
            cyc_addr_q    <= 21'h000000;
            cyc_wdata_q   <= 16'h0000;
            req_taken     <= 1'b0;
            // Strap held in reset; reset must outlast the sync latency
            boot_q        <= boot_pin_s;
        end else begin
            phase_q   <= phase_sum[3:0];
            req_taken <= wrap & req_valid;
            // New cycle: pick divider and take the pending request
            if (wrap) begin
                fast_q        <= ~div_sel_s;
                active_q      <= req_valid;
                cyc_write_q   <= req_write & ~req_refresh;
                cyc_refresh_q <= req_refresh;
                cyc_addr_q    <= req_addr;
                cyc_wdata_q   <= req_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address fields and decode
    wire [4:0]  chapter;               // Address bits AX0..AX4
    wire        bit_ax0;               // Extended bit 0, MSB of chapter
    wire        bit_ax1;               // Extended bit 1
    wire        bit_ax2;               // Extended bit 2
    wire        bit_ax3;               // Extended bit 3
    wire        bit_a14;               // Word address LSB
    wire        in_rom;                // Address ROM range
    wire        in_eprom;              // EPROM range with ROM boot
    wire        access;                // Ordinary read or write cycle

    // Bit 0 is the most significant in the pin numbering
    assign chapter  = cyc_addr_q[20:16];
    assign bit_ax0  = chapter[4];
    assign bit_ax1  = chapter[3];
    assign bit_ax2  = chapter[2];
    assign bit_ax3  = chapter[1];
    assign bit_a14  = cyc_addr_q[1];
    assign in_rom   = (cyc_addr_q <= `LMBP_ROM_LAST);
    assign in_eprom = ~boot_q &
                      (((cyc_addr_q >= `LMBP_EPROM_LO) &
                        (cyc_addr_q <= `LMBP_EPROM_HI)) |
                       (chapter == `LMBP_EPROM_CHAP));
    assign access   = active_q & ~cyc_refresh_q;

    ////////////////////////////////////////////////////////////////////////
    // Quarter decode
    wire        in_q1;                 // First quarter
    wire        in_q2;                 // Second quarter
    wire        in_data;               // Last half
    wire        in_cas;                // Column window after row part
    wire        in_ref_cas;            // Refresh column window
    wire [3:0]  phase_lag;             // Phase delayed a quarter period

    assign in_q1      = (phase_q < `LMBP_Q2_FIRST);
    assign in_q2      = ~in_q1 & (phase_q < `LMBP_DATA_FIRST);
    assign in_data    = (phase_q >= `LMBP_DATA_FIRST);
    assign in_cas     = (phase_q >= `LMBP_CAS_FIRST) &
                        (phase_q <= `LMBP_CAS_LAST);
    assign in_ref_cas = (phase_q <= `LMBP_REF_CAS_LAST);
    assign phase_lag  = phase_q - `LMBP_CLKB_LAG;

    ////////////////////////////////////////////////////////////////////////
    // Parity generation
    wire        wpar_h;                // Parity of high write byte
    wire        wpar_l;                // Parity of low write byte
    wire        rpar_bad;              // Read parity mismatch

    assign wpar_h   = (^cyc_wdata_q[15:8]) ^ PARITY_ODD;
    assign wpar_l   = (^cyc_wdata_q[7:0]) ^ PARITY_ODD;
    assign rpar_bad = ((^lane_h_s) ^ PARITY_ODD ^ par_h_s) |
                      ((^lane_l_s) ^ PARITY_ODD ^ par_l_s);

    ////////////////////////////////////////////////////////////////////////
    // Next pin values from the current phase
    reg         clk_a_d;               // Bus clock one next
    reg         clk_b_d;               // Bus clock two next
    reg         ben_n_d;               // Buffer enable next
    reg         dir_d;                 // Direction next
    reg         rom_oe_n_d;            // Address ROM enable next
    reg         cas_n_d;               // Column strobe next
    reg         upper_d;               // Upper pin level next
    reg         par_h_d;               // High pin level next
    reg         par_l_d;               // Low pin level next
    reg         addr_oe_d;             // Extended pins drive, address
    reg         par_oe_d;              // Parity pins drive

    // All pin outputs share one register stage, so their relative
    // timing matches the phase decode exactly
    always @* begin
        // Bus clocks: period of eight sixteenths, second a quarter late
        clk_a_d    = ~phase_q[2];
        clk_b_d    = ~phase_lag[2];
        // Buffers open only while data is on the lanes
        ben_n_d    = ~(access & in_data);
        // Direction set at cycle start, well before the data half
        dir_d      = access & cyc_write_q;
        // Address ROM enabled for reads of the lowest sixteen bytes
        rom_oe_n_d = ~(access & ~cyc_write_q & in_rom);
        // Column strobe
        if (active_q & cyc_refresh_q) begin
            // Strobe leads the row strobe for column-first refresh
            cas_n_d = ~in_ref_cas;
        end else begin
            // Normal window, blocked for ROM and EPROM ranges
            cas_n_d = ~(access & in_cas & ~in_rom & ~in_eprom);
        end
        // Upper pin: AX2 in first quarter, A14 afterwards
        upper_d    = in_q1 ? bit_ax2 : bit_a14;
        // High and low pins: extended bits, then parity
        if (in_q1) begin
            par_h_d = bit_ax1;
            par_l_d = bit_ax3;
        end else if (in_q2) begin
            par_h_d = bit_ax0;
            par_l_d = bit_ax2;
        end else begin
            par_h_d = wpar_h;
            par_l_d = wpar_l;
        end
        // Address driven on every non-refresh access; parity driven only when writing
        addr_oe_d  = access;
        par_oe_d   = access & (~in_data | cyc_write_q);
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers
    always @(posedge core_clk) begin
        if (!rst_n) begin
            local_bus_clock_a           <= 1'b1;
            local_bus_clock_b           <= 1'b1;
            buffer_enable_n             <= 1'b1;
            data_direction_o            <= 1'b0;
            data_direction_oe           <= 1'b0;
            burned_addr_rom_oe_n        <= 1'b1;
            column_strobe_n             <= 1'b1;
            refresh_in_progress         <= 1'b0;
            ext_addr_upper_pin_o        <= 1'b0;
            ext_addr_upper_pin_oe       <= 1'b0;
            ext_addr_parity_high_pin_o  <= 1'b0;
            ext_addr_parity_high_pin_oe <= 1'b0;
            ext_addr_parity_low_pin_o   <= 1'b0;
            ext_addr_parity_low_pin_oe  <= 1'b0;
            boot_source                 <= 1'b0;
        end else begin
            local_bus_clock_a           <= clk_a_d;
            local_bus_clock_b           <= clk_b_d;
            buffer_enable_n             <= ben_n_d;
            data_direction_o            <= dir_d;
            data_direction_oe           <= `LMBP_DIR_OE_RST;
            burned_addr_rom_oe_n        <= rom_oe_n_d;
            column_strobe_n             <= cas_n_d;
            // Lets board logic gate the strobe for row-first DRAMs
            refresh_in_progress         <= active_q & cyc_refresh_q;
            ext_addr_upper_pin_o        <= upper_d;
            ext_addr_upper_pin_oe       <= addr_oe_d;
            ext_addr_parity_high_pin_o  <= par_h_d;
            ext_addr_parity_high_pin_oe <= par_oe_d;
            ext_addr_parity_low_pin_o   <= par_l_d;
            ext_addr_parity_low_pin_oe  <= par_oe_d;
            boot_source                 <= boot_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read capture and parity check
    // Sampled on the last clock; synchroniser lag means the lanes seen
    // here were on the pins two clocks earlier, still in the data half
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rd_valid     <= 1'b0;
            rd_data      <= 16'h0000;
            parity_error <= 1'b0;
        end else begin
            rd_valid     <= wrap & access & ~cyc_write_q;
            parity_error <= wrap & access & ~cyc_write_q &
                            parity_check_en & rpar_bad;
            // Data held until the next read completes
            if (wrap & access & ~cyc_write_q) begin
                rd_data <= {lane_h_s, lane_l_s};
            end
        end
    end

endmodule

// [test/lmbp_pins_properties.sv]
// Checker for the local-memory bus pin sequencer, bound to lmbp_pins.
// Assumes timing checks, except the direction check, only in settled slow bus mode.
`timescale 1ns/100ps
module lmbp_pins_checker (
    input wire core_clk,              // Core clock
    input wire rst_n,                 // Synchronous reset
    input wire clock_divider_select,  // Divider pin
    input wire local_bus_clock_a,     // Bus clock one
    input wire local_bus_clock_b,     // Bus clock two
    input wire buffer_enable_n,       // Buffer enable
    input wire data_direction_o,      // Direction level
    input wire data_direction_oe,     // Direction drive
    input wire burned_addr_rom_oe_n,  // Address ROM enable
    input wire column_strobe_n,       // Column strobe
    input wire refresh_in_progress,   // Refresh flag
    input wire ext_addr_upper_pin_oe, // Upper pin drive
    input wire ext_addr_parity_low_pin_oe // Low pin drive
);
    ////////////////////////////////
    reg  [5:0] slow_cnt_q; // Core clocks spent in slow mode
    wire       settled;    // Slow mode long enough to trust
    assign settled = (slow_cnt_q == 6'h3F);
    // Saturating count; drops at once so a mode switch never misfires
    always @(posedge core_clk) begin
        if (!rst_n || !clock_divider_select) slow_cnt_q <= 6'h00;
        else if (!settled) slow_cnt_q <= slow_cnt_q + 6'h01;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////
    property p_clk_lag;
        settled |-> local_bus_clock_b == $past(local_bus_clock_a, 2);
    endproperty
    a_clk_lag: assert property (p_clk_lag) else $error("bus clock b lag wrong");
    property p_clk_rate;
        settled && $rose(local_bus_clock_a) |-> local_bus_clock_a[*4] ##1 !local_bus_clock_a[*4];
    endproperty
    a_clk_rate: assert property (p_clk_rate) else $error("bus clock period wrong");
    property p_buf_len;
        settled && $fell(buffer_enable_n) |-> !buffer_enable_n[*8] ##1 buffer_enable_n;
    endproperty
    a_buf_len: assert property (p_buf_len) else $error("buffer enable span wrong");
    property p_buf_ref;
        !buffer_enable_n |-> !refresh_in_progress;
    endproperty
    a_buf_ref: assert property (p_buf_ref) else $error("buffer enabled in refresh");
    property p_dir;
        $fell(buffer_enable_n) |-> data_direction_oe && $stable(data_direction_o)
            && data_direction_o == $past(data_direction_o, 4);
    endproperty
    a_dir: assert property (p_dir) else $error("direction late");
    property p_rom_rd;
        !burned_addr_rom_oe_n |-> !data_direction_o && column_strobe_n && !refresh_in_progress;
    endproperty
    a_rom_rd: assert property (p_rom_rd) else $error("address rom enable wrong");
    property p_cas_len;
        settled && $fell(column_strobe_n) |-> !column_strobe_n[*3] ##1 column_strobe_n;
    endproperty
    a_cas_len: assert property (p_cas_len) else $error("column strobe span wrong");
    property p_cas_pos;
        settled && $fell(column_strobe_n) && !refresh_in_progress |-> !local_bus_clock_a
            && !$past(local_bus_clock_a) && $past(local_bus_clock_a, 2);
    endproperty
    a_cas_pos: assert property (p_cas_pos) else $error("column strobe misplaced");
    property p_cas_pins;
        !column_strobe_n && !refresh_in_progress |-> ext_addr_upper_pin_oe
            && ext_addr_parity_low_pin_oe;
    endproperty
    a_cas_pins: assert property (p_cas_pins) else $error("column address not driven");
    property p_ref_cas;
        settled && $rose(refresh_in_progress) |-> !column_strobe_n ##3 column_strobe_n;
    endproperty
    a_ref_cas: assert property (p_ref_cas) else $error("refresh strobe wrong");
    c_ref: cover property (settled && $rose(refresh_in_progress));
    c_rom: cover property (!burned_addr_rom_oe_n);
    c_wr: cover property ($fell(buffer_enable_n) && data_direction_o);
endmodule
bind lmbp_pins lmbp_pins_checker u_lmbp_pins_checker (.core_clk, .rst_n,
    .clock_divider_select, .local_bus_clock_a, .local_bus_clock_b, .buffer_enable_n,
    .data_direction_o, .data_direction_oe, .burned_addr_rom_oe_n, .column_strobe_n,
    .refresh_in_progress, .ext_addr_upper_pin_oe, .ext_addr_parity_low_pin_oe);

// [test/lmbp_mem_model.sv]
// Far-side memory model: answers reads on the byte lanes.
// Assumes data keyed by the first-quarter extended bits.
`timescale 1ns/100ps
module lmbp_mem_model (
    input  wire       core_clk,   // Core clock
    input  wire       buffer_enable_n,
    input  wire       data_direction_o,
    input  wire       local_bus_clock_a,
    input  wire       upper_pin,  // Upper extended pin
    input  wire       high_pin,   // High extended/parity pin
    input  wire       low_pin,    // Low extended/parity pin
    input  wire       column_strobe_n,
    input  wire       refresh_in_progress,
    input  wire       bad_parity, // Corrupt high parity on demand
    output reg  [7:0] lane_high,
    output reg  [7:0] lane_low,
    output reg        par_high,
    output reg        par_low,
    output wire       dram_cas_n  // Strobe for parts lacking CBR
);
    reg        a_q;    // Bus clock one, last clock
    reg  [2:0] pins_q; // Pins, last clock
    reg  [2:0] ax_q;   // AX3..AX1 of this cycle
    wire [15:0] word = 16'h5A3C ^ {ax_q, 10'h000, ax_q};
    assign dram_cas_n = column_strobe_n | refresh_in_progress;
    initial {lane_high, lane_low, par_high, par_low, ax_q} = 21'h000000;
    // Lanes carry data only while buffers point at the device; else churn
    always @(posedge core_clk) begin
        a_q <= local_bus_clock_a;
        pins_q <= {low_pin, upper_pin, high_pin};
        if (a_q && !local_bus_clock_a) ax_q <= pins_q;
        if (!buffer_enable_n && !data_direction_o) begin
            {lane_high, lane_low} <= word;
            par_high <= ~^word[15:8] ^ bad_parity;
            par_low <= ~^word[7:0];
        end else begin
            {lane_high, lane_low, par_high, par_low} <= ~{lane_high, lane_low, par_high, par_low};
        end
    end
endmodule

// [test/lmbp_pins_tb_top.sv]
// Self-checking bench for the pin sequencer with a memory model.
// Assumes odd parity and the slow bus for every access.
`timescale 1ns/100ps
`define LMBP_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module lmbp_pins_tb_top;
    typedef struct packed {logic rdv; logic [15:0] data; logic perr, cas, rom, bufe, rfr, dir;
        logic [2:0] p1, p5; logic [1:0] par;} lmbp_obs_t;
    logic core_clk, rst_n, clock_divider_select, bootstrap_input, req_valid, req_write;
    logic req_refresh, parity_check_en, bad_parity, boot_exp;
    logic [20:0] req_addr;
    logic [15:0] req_wdata;
    wire [7:0] addr_data_lane_high_i, addr_data_lane_low_i;
    wire ext_addr_parity_high_pin_i, ext_addr_parity_low_pin_i, req_taken, rd_valid;
    wire parity_error, boot_source, local_bus_clock_a, local_bus_clock_b, buffer_enable_n;
    wire data_direction_o, data_direction_oe, burned_addr_rom_oe_n, column_strobe_n;
    wire refresh_in_progress, ext_addr_upper_pin_o, ext_addr_upper_pin_oe;
    wire ext_addr_parity_high_pin_o, ext_addr_parity_high_pin_oe;
    wire ext_addr_parity_low_pin_o, ext_addr_parity_low_pin_oe;
    wire [15:0] rd_data;
    wire [2:0] pin_now = {ext_addr_parity_low_pin_o & ext_addr_parity_low_pin_oe,
        ext_addr_upper_pin_o & ext_addr_upper_pin_oe,
        ext_addr_parity_high_pin_o & ext_addr_parity_high_pin_oe};
    int errors = 0, n_compared = 0, cnt = 0, k;
    integer seed = 32'h16C7D479;
    bit act = 0;
    lmbp_obs_t exp_q[$], o, e;
    lmbp_pins u_lmbp_pins (.*);
    lmbp_mem_model u_lmbp_mem_model (.core_clk, .buffer_enable_n, .data_direction_o,
        .local_bus_clock_a, .upper_pin(ext_addr_upper_pin_o),
        .high_pin(ext_addr_parity_high_pin_o), .low_pin(ext_addr_parity_low_pin_o),
        .column_strobe_n, .refresh_in_progress, .bad_parity,
        .lane_high(addr_data_lane_high_i), .lane_low(addr_data_lane_low_i),
        .par_high(ext_addr_parity_high_pin_i), .par_low(ext_addr_parity_low_pin_i),
        .dram_cas_n());
    ////////////////////////////////
    initial begin
        core_clk = 0;
        forever #12.5 core_clk = ~core_clk;
    end
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Plan runs under 2000 clocks; 20000 means a hang
    initial begin
        #500000;
        errors++;
        print_verdict;
    end
    ////////////////////////////////
    // Queue a request, then hold it until the taken pulse shows
    task access(input logic wr, rf, input logic [20:0] a, input logic pe);
        lmbp_obs_t x;
        logic [15:0] wd;
        wd = $random(seed);
        x.rfr = rf;
        x.rdv = !wr && !rf;
        x.data = x.rdv ? 16'h5A3C ^ {a[17], a[18], a[19], 10'h000, a[17], a[18], a[19]} : 16'h0000;
        x.perr = x.rdv & pe;
        x.cas = rf || !(a <= 21'h00000F || (!boot_exp && (a <= 21'h00FFFF || a[20:16] == 5'h1F)));
        x.rom = x.rdv && a <= 21'h00000F;
        x.bufe = !rf;
        x.dir = wr && !rf;
        x.p1 = rf ? 3'h0 : {a[17], a[18], a[19]};
        x.p5 = rf ? 3'h0 : {a[18], a[1], a[20]};
        x.par = x.dir ? {~^wd[15:8], ~^wd[7:0]} : 2'h0;
        exp_q.push_back(x);
        req_valid <= 1'b1;
        req_write <= wr;
        req_refresh <= rf;
        req_addr <= a;
        req_wdata <= wd;
        k = 0;
        do begin @(posedge core_clk); k++; end while (req_taken !== 1'b1 && k < 40);
        if (k >= 40) errors++;
    endtask
    task stop(input string name);
        req_valid <= 1'b0;
        k = 0;
        do begin @(posedge core_clk); k++; end while ((act || exp_q.size() != 0) && k < 40);
        if (k >= 40) errors++;
        $display("test %0s done", name);
    endtask
    task do_reset(input logic b);
        bootstrap_input <= b;
        rst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        boot_exp = b;
        repeat (2) @(posedge core_clk);
        `LMBP_CHK(boot_source, b)
    endtask
    function logic [20:0] dram_addr;
        logic [20:0] a;
        a = $random(seed);
        a[20:16] = 5'h01 + a[20:16] % 5'h1E;
        return a;
    endfunction
    // Count bus clock rises over 64 core clocks
    task clk_rate(input logic sel, input int want);
        int n;
        logic pa;
        clock_divider_select <= sel;
        repeat (40) @(posedge core_clk);
        n = 0;
        pa = local_bus_clock_a;
        repeat (64) begin
            @(posedge core_clk);
            n += local_bus_clock_a && !pa;
            pa = local_bus_clock_a;
        end
        `LMBP_CHK(n, want)
    endtask
    ////////////////////////////////
    // Monitor: close each memory cycle after sixteen samples
    always @(posedge core_clk) begin
        if (!rst_n) act = 0;
        else begin
            if (act) begin
                cnt++;
                o.cas |= !column_strobe_n;
                o.rom |= !burned_addr_rom_oe_n;
                o.bufe |= !buffer_enable_n;
                o.rfr |= refresh_in_progress;
                if (rd_valid) {o.rdv, o.data, o.perr} = {1'b1, rd_data, parity_error};
                if (cnt == 1) o.p1 = pin_now;
                if (cnt == 5) o.p5 = pin_now;
                if (cnt == 9) {o.par, o.dir} = {pin_now[0], pin_now[2], data_direction_o};
                if (cnt == 16) begin
                    `LMBP_CHK(o, e)
                    act = 0;
                end
            end
            if (req_taken) begin
                e = exp_q.pop_front();
                o = '0;
                cnt = 0;
                act = 1;
            end
        end
    end
    ////////////////////////////////
    initial begin
        {rst_n, req_valid, req_write, req_refresh, parity_check_en, bad_parity} = 6'h00;
        {clock_divider_select, bootstrap_input, req_addr, req_wdata} = 39'h4000000000;
        do_reset(1'b0);
        access(0, 0, {17'h00000, 4'($random(seed))}, 0);
        access(1, 0, 21'h00000F, 0);
        access(0, 0, 21'h000010, 0);
        access(0, 0, {5'h1F, 16'($random(seed))}, 0);
        access(1, 0, dram_addr(), 0);
        access(0, 0, dram_addr(), 0);
        access(0, 1, 21'h000000, 0);
        access(0, 1, 21'h000000, 0);
        access(0, 0, dram_addr(), 0);
        stop("mixed");
        {bad_parity, parity_check_en} <= 2'h3;
        access(0, 0, dram_addr(), 1);
        stop("parity");
        parity_check_en <= 1'b0;
        access(0, 0, dram_addr(), 0);
        stop("unchecked");
        bad_parity <= 1'b0;
        do_reset(1'b1);
        access(0, 0, 21'h000010, 0);
        access(1, 0, {5'h1F, 16'($random(seed))}, 0);
        access(0, 0, 21'h00000F, 0);
        stop("boot");
        clk_rate(1'b0, 16);
        clk_rate(1'b1, 8);
        $display("test rates done");
        print_verdict;
    end
endmodule
